// ===== seao_audio_out.v
// Sound effect synthesizer, sample playback mixer and mono PWM audio output
//
// Behaviour
// - Audio leaves as one mono PWM waveform on a single output pin.
// - Synthesizer and sample playback both feed the same mono PWM output.
// - Effects come from a small built-in wavetable ROM chosen by effect code.
// - Play trigger reads 1 while the effect sounds, 0 once it finishes.
// - Looping effects sound until interrupted or replaced; play status stays 1.
// - New code plus play write aborts current effect; code 0 means silence.
// - Effect loudness is scaled by a separate effect volume register.
// - Effect select register is 16 bits; effect code sits in low byte.
// - For pitch effects the upper byte is a MIDI note setting pitch.
// - For pitch effects a note of zero gives middle C.
// - Non-pitch effects ignore the upper byte of the select register.
// - Any playback trigger write with a nonzero length starts playback; reads 1 while running.
`timescale 1ns/1ns
`default_nettype none
`include "seao_defines.vh"

module seao_audio_out #(
  parameter ONESHOT_SAMPLES = `SEAO_ONESHOT_SAMPLES
) (
  input wire clk_sys,
  input wire rst,
  input wire reg_wr,
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire [7:0] pb_sample,
  output reg pb_fetch,
  output reg audio_pwm
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Quarter-wave sine magnitude, k = 0..8
  function [6:0] seao_sin_q;
    input [3:0] k;
    begin
      case (k)
        4'h0: seao_sin_q = 7'h00;
        4'h1: seao_sin_q = 7'h19;
        4'h2: seao_sin_q = 7'h31;
        4'h3: seao_sin_q = 7'h47;
        4'h4: seao_sin_q = 7'h5a;
        4'h5: seao_sin_q = 7'h6a;
        4'h6: seao_sin_q = 7'h75;
        4'h7: seao_sin_q = 7'h7d;
        default: seao_sin_q = 7'h7f;
      endcase
    end
  endfunction

  // Phase increment per sample for the notes of the base octave
  function [23:0] seao_semitone_inc;
    input [3:0] s;
    begin
      case (s)
        4'h0: seao_semitone_inc = 24'h00db78;
        4'h1: seao_semitone_inc = 24'h00e884;
        4'h2: seao_semitone_inc = 24'h00f657;
        4'h3: seao_semitone_inc = 24'h01050f;
        4'h4: seao_semitone_inc = 24'h011484;
        4'h5: seao_semitone_inc = 24'h0124f5;
        4'h6: seao_semitone_inc = 24'h01365f;
        4'h7: seao_semitone_inc = 24'h0148d5;
        4'h8: seao_semitone_inc = 24'h015c61;
        4'h9: seao_semitone_inc = 24'h017119;
        4'ha: seao_semitone_inc = 24'h01870b;
        default: seao_semitone_inc = 24'h019e4c;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [15:0] sound_select_reg;
  reg [7:0] effect_volume_reg;
  reg [7:0] pb_volume_reg;
  reg [15:0] pb_length_reg;
  reg effect_playing_reg;
  reg [7:0] active_code_reg;
  reg [6:0] active_note_reg;
  reg [15:0] effect_left_reg;
  reg pb_playing_reg;
  reg [15:0] pb_left_reg;
  reg [7:0] pb_cur_reg;
  reg [7:0] pwm_cnt_reg;
  reg [7:0] duty_reg;
  reg [23:0] phase_reg;
  reg [15:0] lfsr_reg;

  wire sample_tick = (pwm_cnt_reg == 8'hff);
  wire play_wr = reg_wr && (reg_addr == `SEAO_ADDR_EFFECT_PLAY) && (reg_wdata[0] == 1'b1);
  wire pb_wr = reg_wr && (reg_addr == `SEAO_ADDR_PB_PLAY);
  wire [7:0] sel_code = sound_select_reg[7:0];
  wire [7:0] sel_note = sound_select_reg[15:8];

  // ----------------------------------------------------------------
  // Host register writes and reads
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      sound_select_reg <= `SEAO_RST_SOUND_SELECT;
      effect_volume_reg <= `SEAO_RST_EFFECT_VOLUME;
      pb_volume_reg <= `SEAO_RST_PB_VOLUME;
      pb_length_reg <= `SEAO_RST_PB_LENGTH;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `SEAO_ADDR_SOUND_SELECT: sound_select_reg <= reg_wdata;
          `SEAO_ADDR_EFFECT_VOLUME: effect_volume_reg <= reg_wdata[7:0];
          `SEAO_ADDR_PB_VOLUME: pb_volume_reg <= reg_wdata[7:0];
          `SEAO_ADDR_PB_LENGTH: pb_length_reg <= reg_wdata;
          default: ;
        endcase
      end
      case (reg_addr)
        `SEAO_ADDR_SOUND_SELECT: reg_rdata <= sound_select_reg;
        `SEAO_ADDR_EFFECT_PLAY: reg_rdata <= {15'h0000, effect_playing_reg};
        `SEAO_ADDR_EFFECT_VOLUME: reg_rdata <= {8'h00, effect_volume_reg};
        `SEAO_ADDR_PB_PLAY: reg_rdata <= {15'h0000, pb_playing_reg};
        `SEAO_ADDR_PB_VOLUME: reg_rdata <= {8'h00, pb_volume_reg};
        `SEAO_ADDR_PB_LENGTH: reg_rdata <= pb_length_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Effect sequencing
  // ----------------------------------------------------------------
  // The code and note are latched at the trigger, so rewriting the select
  // register alone does not disturb an effect that is already sounding.
  always @(posedge clk_sys) begin
    if (rst) begin
      effect_playing_reg <= 1'b0;
      active_code_reg <= `SEAO_CODE_SILENCE;
      active_note_reg <= `SEAO_MIDDLE_C_NOTE;
      effect_left_reg <= 16'h0000;
    end else if (play_wr) begin
      active_code_reg <= sel_code;
      effect_playing_reg <= (sel_code != `SEAO_CODE_SILENCE);
      effect_left_reg <= ONESHOT_SAMPLES;
      if (sel_code[`SEAO_CODE_PITCH_BIT] && (sel_note[6:0] != 7'h00) && !sel_note[7]) begin
        active_note_reg <= sel_note[6:0];
      end else begin
        active_note_reg <= `SEAO_MIDDLE_C_NOTE;
      end
    end else if (effect_playing_reg && sample_tick && !active_code_reg[`SEAO_CODE_LOOP_BIT]) begin
      // Looping codes never count down and stay playing
      if (effect_left_reg == 16'h0001) begin
        effect_playing_reg <= 1'b0;
      end
      effect_left_reg <= effect_left_reg - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Wavetable synthesis
  // ----------------------------------------------------------------
  reg [3:0] octave;
  reg [3:0] semitone;
  reg [23:0] phase_inc;
  reg [7:0] wave;
  reg [3:0] sin_k;
  // Quotient and remainder of a 7-bit note always fit in 4 bits
  wire [6:0] note_oct = active_note_reg / 7'd12;
  wire [6:0] note_semi = active_note_reg % 7'd12;
  always @* begin
    octave = 4'h0;
    semitone = 4'h0;
    sin_k = 4'h0;
    octave = note_oct[3:0];
    semitone = note_semi[3:0];
    if (octave >= `SEAO_BASE_OCTAVE) begin
      phase_inc = seao_semitone_inc(semitone) << (octave - `SEAO_BASE_OCTAVE);
    end else begin
      phase_inc = seao_semitone_inc(semitone) >> (`SEAO_BASE_OCTAVE - octave);
    end
    sin_k = phase_reg[21] ? (4'h8 - {1'b0, phase_reg[20:18]}) : {1'b0, phase_reg[20:18]};
    case (active_code_reg[`SEAO_CODE_WAVE_MSB:`SEAO_CODE_WAVE_LSB])
      `SEAO_WAVE_SINE: wave = phase_reg[22] ? (8'h00 - {1'b0, seao_sin_q(sin_k)}) : {1'b0, seao_sin_q(sin_k)};
      `SEAO_WAVE_SQUARE: wave = phase_reg[23] ? 8'h81 : 8'h7f;
      `SEAO_WAVE_TRIANGLE: wave = phase_reg[23] ? (8'h7f - {phase_reg[22:16], 1'b0}) :
                                                 ({phase_reg[22:16], 1'b0} - 8'h80);
      default: wave = lfsr_reg[7:0];
    endcase
    if (!effect_playing_reg) begin
      wave = 8'h00;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      phase_reg <= 24'h000000;
      lfsr_reg <= `SEAO_LFSR_SEED;
    end else if (play_wr) begin
      phase_reg <= 24'h000000;
    end else if (sample_tick) begin
      phase_reg <= phase_reg + phase_inc;
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // ----------------------------------------------------------------
  // Sample playback
  // ----------------------------------------------------------------
  // The source must present the next sample by the following sample tick.
  always @(posedge clk_sys) begin
    if (rst) begin
      pb_playing_reg <= 1'b0;
      pb_left_reg <= 16'h0000;
      pb_cur_reg <= 8'h00;
      pb_fetch <= 1'b0;
    end else begin
      pb_fetch <= 1'b0;
      if (pb_wr) begin
        pb_playing_reg <= (pb_length_reg != 16'h0000);
        pb_left_reg <= pb_length_reg;
        pb_cur_reg <= 8'h00;
      end else if (pb_playing_reg && sample_tick) begin
        pb_cur_reg <= pb_sample;
        pb_fetch <= 1'b1;
        pb_left_reg <= pb_left_reg - 16'h0001;
        if (pb_left_reg == 16'h0001) begin
          pb_playing_reg <= 1'b0;
        end
      end else if (!pb_playing_reg && sample_tick) begin
        pb_cur_reg <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mixing and PWM
  // ----------------------------------------------------------------
  wire signed [16:0] syn_prod = $signed(wave) * $signed({1'b0, effect_volume_reg});
  wire signed [16:0] pb_prod = $signed(pb_cur_reg) * $signed({1'b0, pb_volume_reg});
  wire signed [9:0] mix_sum = $signed(syn_prod[16:8]) + $signed(pb_prod[16:8]);
  reg [7:0] mix_sat;
  always @* begin
    if (mix_sum > $signed(10'h07f)) begin
      mix_sat = 8'h7f;
    end else if (mix_sum < $signed(10'h380)) begin
      mix_sat = 8'h80;
    end else begin
      mix_sat = mix_sum[7:0];
    end
  end

  // Duty only changes at the period boundary so no pulse is ever split
  always @(posedge clk_sys) begin
    if (rst) begin
      pwm_cnt_reg <= 8'h00;
      duty_reg <= 8'h80;
      audio_pwm <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      if (sample_tick) begin
        duty_reg <= {~mix_sat[7], mix_sat[6:0]};
      end
      audio_pwm <= (pwm_cnt_reg < duty_reg);
    end
  end

endmodule // seao_audio_out
`default_nettype wire

// ===== seao_audio_out_bench.sv
// Self-checking bench for the sound effect audio output
`timescale 1ns/1ns
`default_nettype none
module seao_audio_out_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [7:0] src = 8'h00;
  wire [15:0] reg_rdata;
  wire [7:0] pb_sample;
  wire pb_fetch;
  wire audio_pwm;
  wire [8:0] level;
  int error_cnt = 0;
  int cmp_count = 0;
  always #25 clk_sys = ~clk_sys;
  // Short one-shot keeps the run brief
  seao_audio_out #(.ONESHOT_SAMPLES(16'h0004)) u_seao_audio_out (.clk_sys(clk_sys), .rst(rst),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pb_sample(pb_sample), .pb_fetch(pb_fetch), .audio_pwm(audio_pwm));
  seao_far_side u_seao_far_side (.clk_sys(clk_sys), .rst(rst), .audio_pwm(audio_pwm),
    .pb_fetch(pb_fetch), .src(src), .pb_sample(pb_sample), .level(level));
  task summarize;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk16(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk9(input logic [8:0] g, input logic [8:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [15:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    chk16(reg_rdata, e);
  endtask
  task frames;
    repeat (600) @(negedge clk_sys);
  endtask
  task wfetch;
    int i;
    i = 0;
    while (!pb_fetch && i < 600) begin
      @(negedge clk_sys);
      i++;
    end
    chk16({15'h0000, pb_fetch}, 16'h0001);
    @(negedge clk_sys);
  endtask
  task t_defaults;
    rd(3'h0, 16'h0000);
    rd(3'h2, 16'h00ff);
    rd(3'h4, 16'h00ff);
    rd(3'h5, 16'h0000);
    rd(3'h6, 16'h0000);
    frames;
    chk9(level, 9'h080);
  endtask
  task t_effect;
    wr(3'h2, 16'h0000);
    wr(3'h0, 16'h4041);
    wr(3'h1, 16'h0001);
    rd(3'h1, 16'h0001);
    frames;
    chk9(level, 9'h080);
    wr(3'h2, 16'h00ff);
    frames;
    chk16({15'h0000, level != 9'h080}, 16'h0001);
    repeat (3) frames;
    rd(3'h1, 16'h0001);
    wr(3'h0, 16'h0000);
    wr(3'h1, 16'h0001);
    rd(3'h1, 16'h0000);
    wr(3'h0, 16'h7f02);
    rd(3'h0, 16'h7f02);
    wr(3'h1, 16'h0001);
    rd(3'h1, 16'h0001);
    repeat (3) frames;
    rd(3'h1, 16'h0000);
  endtask
  task lows(input logic [15:0] sel, output int n);
    wr(3'h0, sel);
    wr(3'h1, 16'h0001);
    frames;
    n = 0;
    repeat (8) begin
      repeat (256) @(negedge clk_sys);
      if (level < 9'h080) n++;
    end
  endtask
  task t_pitch;
    int n;
    wr(3'h2, 16'h00ff);
    // Middle C takes far longer than eight frames to reach its low half
    lows(16'h00c1, n);
    chk16(n[15:0], 16'h0000);
    lows(16'h7f41, n);
    chk16(n[15:0], 16'h0000);
    // The top note swings low within a few samples
    lows(16'h7fc1, n);
    chk16({15'h0000, n != 0}, 16'h0001);
    wr(3'h0, 16'h0000);
    wr(3'h1, 16'h0001);
  endtask
  task t_playback;
    wr(3'h5, 16'h0000);
    wr(3'h3, 16'h0001);
    rd(3'h3, 16'h0000);
    wr(3'h5, 16'h0002);
    src = 8'h7f;
    wr(3'h3, 16'h0000);
    rd(3'h3, 16'h0001);
    wfetch;
    wfetch;
    repeat (2) @(negedge clk_sys);
    rd(3'h3, 16'h0000);
    wr(3'h4, 16'h00ff);
    wr(3'h5, 16'h0008);
    wr(3'h3, 16'h0001);
    repeat (2) frames;
    // 127 scaled by 255, shifted down 8, plus midscale
    chk9(level, 9'h0fe);
    wr(3'h0, 16'h0041);
    wr(3'h1, 16'h0001);
    wr(3'h3, 16'h0001);
    repeat (2) frames;
    // Both sources at full scale must clip, not wrap
    chk9(level, 9'h0ff);
    wr(3'h0, 16'h0000);
    wr(3'h1, 16'h0001);
    wr(3'h4, 16'h0080);
    wr(3'h3, 16'h0001);
    repeat (2) frames;
    // 127 scaled by 128 and shifted down 8 gives 63 above midscale
    chk9(level, 9'h0bf);
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    t_defaults;
    t_effect;
    t_pitch;
    t_playback;
    summarize;
  end
  initial begin
    #2000000;
    error_cnt++;
    summarize;
  end
endmodule // seao_audio_out_bench
`default_nettype wire

// ===== seao_audio_out_properties.sv
// Concurrent checks on the audio output ports
`timescale 1ns/1ns
`default_nettype none
module seao_checker #(
  parameter ONESHOT_SAMPLES = 16'h9897
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0] pb_sample,
  input wire logic pb_fetch,
  input wire logic audio_pwm
);
  // Mirrors the PWM counter, which restarts with reset
  logic [7:0] frame_reg;
  always @(posedge clk_sys) begin
    if (rst) frame_reg <= 8'h00;
    else frame_reg <= frame_reg + 8'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence wr_idle(logic [2:0] a);
    reg_wr && reg_addr == a ##1 reg_addr == a && !reg_wr;
  endsequence
  sequence code_wr(logic z);
    reg_wr && reg_addr == 3'h0 && ((reg_wdata[7:0] == 8'h00) == z);
  endsequence
  sequence play_rd;
    reg_wr && reg_addr == 3'h1 && reg_wdata[0] ##1 reg_addr == 3'h1 && !reg_wr;
  endsequence
  rst_clear_a: assert property (disable iff (1'b0)
    rst |=> reg_rdata == 16'h0000 && !pb_fetch && !audio_pwm) else $error("outputs not cleared");
  eff_vol_a: assert property (wr_idle(3'h2) |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)})
    else $error("effect volume readback");
  pb_vol_a: assert property (wr_idle(3'h4) |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)})
    else $error("playback volume readback");
  select_rb_a: assert property (wr_idle(3'h0) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("select readback");
  silence_stop_a: assert property (code_wr(1'b1) ##2 play_rd |=> reg_rdata == 16'h0000)
    else $error("silence still playing");
  play_busy_a: assert property (code_wr(1'b0) ##2 play_rd |=> reg_rdata == 16'h0001)
    else $error("effect not playing");
  refused_rd_a: assert property (reg_addr[2:1] == 2'b11 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  fetch_once_a: assert property (pb_fetch |=> !pb_fetch [*8])
    else $error("fetch pulse too long");
  fetch_tick_a: assert property (pb_fetch |-> frame_reg == 8'h00)
    else $error("fetch off the sample tick");
  pwm_frame_a: assert property (frame_reg == 8'h00 |-> !audio_pwm)
    else $error("pwm high past duty range");
endmodule // seao_checker
bind seao_audio_out seao_checker #(.ONESHOT_SAMPLES(ONESHOT_SAMPLES)) u_seao_checker (.clk_sys(clk_sys),
  .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .pb_sample(pb_sample), .pb_fetch(pb_fetch), .audio_pwm(audio_pwm));
`default_nettype wire

// ===== seao_defines.vh
// Register offsets, field positions, reset values and timing counts for the sound effect audio output
`ifndef SEAO_DEFINES_VH
`define SEAO_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------
`define SEAO_ADDR_SOUND_SELECT 3'h0
`define SEAO_ADDR_EFFECT_PLAY 3'h1
`define SEAO_ADDR_EFFECT_VOLUME 3'h2
`define SEAO_ADDR_PB_PLAY 3'h3
`define SEAO_ADDR_PB_VOLUME 3'h4
`define SEAO_ADDR_PB_LENGTH 3'h5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEAO_RST_SOUND_SELECT 16'h0000
`define SEAO_RST_EFFECT_VOLUME 8'hff
`define SEAO_RST_PB_VOLUME 8'hff
`define SEAO_RST_PB_LENGTH 16'h0000

// ----------------------------------------------------------------
// Effect code fields (low byte of the select register)
// ----------------------------------------------------------------
`define SEAO_CODE_SILENCE 8'h00
`define SEAO_CODE_PITCH_BIT 7
`define SEAO_CODE_LOOP_BIT 6
`define SEAO_CODE_WAVE_MSB 1
`define SEAO_CODE_WAVE_LSB 0
`define SEAO_WAVE_SINE 2'h0
`define SEAO_WAVE_SQUARE 2'h1
`define SEAO_WAVE_TRIANGLE 2'h2
`define SEAO_WAVE_NOISE 2'h3

// ----------------------------------------------------------------
// Pitch and timing
// ----------------------------------------------------------------
`define SEAO_MIDDLE_C_NOTE 7'h3c
`define SEAO_BASE_OCTAVE 4'h5
`define SEAO_ONESHOT_SAMPLES 16'h9897
`define SEAO_LFSR_SEED 16'hace1

`endif

// ===== seao_far_side.sv
// Output filter model and playback sample source
`timescale 1ns/1ns
`default_nettype none
module seao_far_side (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic audio_pwm,
  input wire logic pb_fetch,
  input wire logic [7:0] src,
  output logic [7:0] pb_sample,
  output logic [8:0] level
);
  logic [7:0] cnt_reg;
  logic [8:0] acc_reg;
  // Averages the pulse over one 256-cycle frame, as the filter would
  always @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      acc_reg <= 9'h000;
      level <= 9'h000;
      pb_sample <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == 8'h00) begin
        level <= acc_reg;
        acc_reg <= 9'h000;
      end else acc_reg <= acc_reg + {8'h00, audio_pwm};
      if (pb_fetch) pb_sample <= src;
    end
  end
endmodule // seao_far_side
`default_nettype wire
